// ---- dv/fxh_dev_model.sv ----
// Behavioural model of one cascade buffer device driven by the host.
// Assumes the host's strobes; storage kept short through DEPTH.
`timescale 1ns/1ps
module fxh_dev_model #(
  parameter int DEPTH = 8
) (
  input  wire logic       write_strobe_n,
  input  wire logic       read_strobe_n,
  input  wire logic       clear_input_n,
  input  wire logic       chain_head_select,
  input  wire logic       chain_token_in,
  input  wire logic [8:0] wdata_pins,
  output logic      [8:0] rdata_pins,
  output logic            no_room_ind,
  output logic            no_data_ind,
  output logic            half_level_ind
);
  logic [8:0] mem [DEPTH];
  logic [8:0] q_q;
  logic       chain_q, head_q, wok, rok, hf_q, xo_q;
  int         wp, rp, cnt, ntok;
  // Clear puts both pointers first; straps are taken on its release
  always @(clear_input_n) begin
    wp = 0;
    rp = 0;
    cnt = 0;
    ntok = 0;
    hf_q = 1'b1;
    xo_q = 1'b1;
    chain_q = chain_token_in;
    head_q = chain_head_select;
  end
  // Token pulses open a non-head device: writes after one, reads after two
  always @(posedge chain_token_in) if (clear_input_n) ntok++;
  // Writes while full or while gated are dropped; half flag falls
  always @(negedge write_strobe_n) begin
    wok = cnt < DEPTH && (!chain_q || !head_q || ntok > 0);
    if (wok && cnt >= DEPTH / 2) hf_q = 1'b0;
    if (wok && chain_q && wp == DEPTH - 1) xo_q = 1'b0;
  end
  // Chain output pulse ends with the strobe that started it
  always @(posedge write_strobe_n or posedge read_strobe_n) xo_q = 1'b1;
  always @(posedge write_strobe_n) if (wok && clear_input_n) begin
    mem[wp] = wdata_pins;
    wp = (wp + 1) % DEPTH;
    cnt++;
  end
  // No replay input exists, as in a depth chain
  always @(negedge read_strobe_n) begin
    rok = cnt > 0 && (!chain_q || !head_q || ntok > 1);
    if (rok) q_q = mem[rp];
    if (rok && chain_q && rp == DEPTH - 1) xo_q = 1'b0;
  end
  always @(posedge read_strobe_n) if (rok && clear_input_n) begin
    rp = (rp + 1) % DEPTH;
    cnt--;
    if (cnt <= DEPTH / 2) hf_q = 1'b1;
  end
  // Released output bus shows the inverse so stale data never matches
  assign rdata_pins = read_strobe_n ? ~q_q : q_q;
  assign no_room_ind = cnt < DEPTH;
  assign no_data_ind = cnt > 0;
  assign half_level_ind = chain_q ? xo_q : hf_q;
endmodule

// ---- dv/fxh_host_checker.sv ----
// Checker of the host's pin sequencing, bound onto fxh_host.
// Assumes device flags that stay steady between strobes.
`timescale 1ns/1ps
module fxh_host_checker (
  input wire logic                   hclk,
  input wire logic                   hresetn,
  input wire logic                   hreadyout,
  input wire logic                   hresp,
  input wire logic                   write_strobe_n,
  input wire logic                   read_strobe_n,
  input wire logic                   clear_input_n,
  input wire logic                   chain_head_select,
  input wire logic [fxh_pkg::DW-1:0] wdata_pins,
  input wire logic                   no_room_ind
);
  logic [7:0] w_q, r_q, c_q, s_q, f_q;
  // Low-time counters of the strobes and of clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) w_q <= 8'h00;
    else w_q <= write_strobe_n ? 8'h00 : w_q + 8'h01;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) r_q <= 8'h00;
    else r_q <= read_strobe_n ? 8'h00 : r_q + 8'h01;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) c_q <= 8'h00;
    else c_q <= clear_input_n ? 8'h00 : c_q + 8'h01;
  end
  // Cycles since clear release; saturates so a long run never wraps
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) s_q <= 8'hff;
    else if (!clear_input_n) s_q <= 8'h00;
    else s_q <= s_q + {7'h00, s_q != 8'hff};
  end
  // How long the room indication has been low, saturating
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) f_q <= 8'h00;
    else if (no_room_ind) f_q <= 8'h00;
    else f_q <= f_q + {7'h00, f_q != 8'hff};
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_wr_width: assert property ($rose(write_strobe_n) |->
    w_q == fxh_pkg::PULSE_C) else $error("write strobe width wrong");
  a_rd_width: assert property ($rose(read_strobe_n) |->
    r_q == fxh_pkg::PULSE_C) else $error("read strobe width wrong");
  a_clr_width: assert property ($rose(clear_input_n) |->
    c_q == fxh_pkg::PULSE_C) else $error("clear width wrong");
  a_clr_quiet: assert property ((!clear_input_n ||
    s_q < fxh_pkg::SETUP_C) |-> write_strobe_n && read_strobe_n)
    else $error("strobe active near clear");
  a_strobe_recover: assert property ($rose(write_strobe_n) ||
    $rose(read_strobe_n) |-> (write_strobe_n && read_strobe_n)[*4])
    else $error("strobe recovery too short");
  a_wdata_steady: assert property (!write_strobe_n &&
    !$past(write_strobe_n) |-> $stable(wdata_pins))
    else $error("write data moved under strobe");
  a_strap_held: assert property (!clear_input_n &&
    !$past(clear_input_n) |-> $stable(chain_head_select))
    else $error("head strap moved during clear");
  a_full_blocks: assert property ($fell(write_strobe_n) |->
    f_q < 8'h06) else $error("write strobe while full");
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus response not ready okay");
  c_write: cover property ($fell(write_strobe_n));
  c_read: cover property ($fell(read_strobe_n));
  c_clear: cover property ($rose(clear_input_n));
endmodule

bind fxh_host fxh_host_checker i_chk (
  .hclk, .hresetn, .hreadyout, .hresp, .write_strobe_n, .read_strobe_n,
  .clear_input_n, .chain_head_select, .wdata_pins, .no_room_ind
);

// ---- dv/fxh_host_test.sv ----
// Self-checking bench of the buffer host against the device model.
// Assumes the host's zero-wait slave and an eight-word model depth.
`timescale 1ns/1ps
module fxh_host_test;
  localparam int DEPTH = 8;
  logic        hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0, nb_tok = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd_s, v;
  logic [1:0]  htrans = 2'h0;
  wire         hreadyout, hresp, write_strobe_n, read_strobe_n;
  wire         clear_input_n, chain_head_select, chain_token_drv;
  wire         chain_token_oe, no_room_ind, no_data_ind, half_level_ind;
  wire  [31:0] hrdata;
  wire  [8:0]  wdata_pins, rdata_pins;
  // A released token pin shows the neighbour's output, idle low
  wire         tok = chain_token_oe ? chain_token_drv : nb_tok;
  int          n_errors = 0, n_tests = 0, seed = 24, cyc = 0;
  typedef struct {string nm; logic [31:0] m; logic [31:0] e;} fxh_note_t;
  fxh_note_t   exp_q [$];
  logic [8:0]  dq [$];
  event        got;
  fxh_host i_dut (.hsel(1'b1), .hready(hreadyout), .hsize(3'h2),
    .hclk, .hresetn, .haddr, .htrans, .hwrite, .hwdata, .hreadyout,
    .hresp, .hrdata, .write_strobe_n, .read_strobe_n, .clear_input_n,
    .chain_head_select, .chain_token_drv, .chain_token_oe, .wdata_pins,
    .rdata_pins, .no_room_ind, .no_data_ind, .half_level_ind);
  fxh_dev_model #(.DEPTH(DEPTH)) i_dev (.chain_token_in(tok),
    .write_strobe_n, .read_strobe_n, .clear_input_n, .chain_head_select,
    .wdata_pins, .rdata_pins, .no_room_ind, .no_data_ind, .half_level_ind);
  // Clock and a cycle ceiling well above the expected run
  always #2.5 hclk = ~hclk;
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      wrap_up();
    end
  end
  task automatic check(string nm, logic [31:0] s, logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Watcher takes the oldest note off the queue for each read result
  always @(got) begin
    fxh_note_t n;
    n = exp_q.pop_front();
    check(n.nm, rd_s & n.m, n.e & n.m);
  end
  // One single transfer; the master waits for hready in both phases
  task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge hclk);
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd_s = hrdata;
  endtask
  task automatic rd(logic [7:0] a, string nm, logic [31:0] m,
                    logic [31:0] e);
    exp_q.push_back('{nm, m, e});
    bus(1'b0, a, 32'h0);
    -> got;
  endtask
  // Issue a command, then poll busy so commands never overlap
  task automatic cmd(logic [31:0] c);
    int k;
    bus(1'b1, fxh_pkg::REG_CTRL, c);
    k = 0;
    do begin
      bus(1'b0, fxh_pkg::REG_STATUS, 32'h0);
      k++;
    end while (rd_s[fxh_pkg::ST_BUSY] !== 1'b0 && k < 100);
    if (k >= 100) n_errors++;  // Busy never cleared counts as a mismatch
  endtask
  // Neighbour's token pulse: one pulse width high, then recovery
  task automatic tok_pulse();
    nb_tok <= 1'b1;
    repeat (fxh_pkg::PULSE_CYC) @(posedge hclk);
    nb_tok <= 1'b0;
    repeat (fxh_pkg::RECOV_CYC) @(posedge hclk);
  endtask
  // Status bits refused, half low, data ok, room ok
  task automatic st(string nm, logic [3:0] e);
    rd(fxh_pkg::REG_STATUS, nm, 32'h0000001e, {27'h0, e, 1'b0});
  endtask
  task automatic wrap_up();
    $display("Counts: %0d checks, %0d errors", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    cmd(32'h00000003);
    st("empty", 4'b0001);
    for (int i = 1; i <= DEPTH; i++) begin
      v = $random(seed);
      v = v & 32'h000001ff;
      dq.push_back(v[8:0]);
      bus(1'b1, fxh_pkg::REG_WDATA, v);
      cmd(32'h00000001);
      st("fill", {1'b0, i > DEPTH / 2, 1'b1, i < DEPTH});
    end
    cmd(32'h00000001);
    st("overflow", 4'b1110);
    $display("Test fill done");
    for (int i = DEPTH - 1; i >= 0; i--) begin
      cmd(32'h00000002);
      rd(fxh_pkg::REG_RDATA, "data", 32'h1ff, {23'h0, dq.pop_front()});
      st("drain", {1'b0, i > DEPTH / 2, i > 0, 1'b1});
    end
    cmd(32'h00000002);
    st("underflow", 4'b1001);
    $display("Test drain done");
    cmd(32'h00000073);
    bus(1'b1, fxh_pkg::REG_WDATA, 32'h00000155);
    cmd(32'h00000001);
    st("gated", 4'b0001);
    tok_pulse();
    cmd(32'h00000001);
    st("owned", 4'b0011);
    cmd(32'h00000002);
    st("read gated", 4'b0011);
    tok_pulse();
    cmd(32'h00000002);
    rd(fxh_pkg::REG_RDATA, "chain data", 32'h1ff, 32'h00000155);
    st("chain drained", 4'b0001);
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    cmd(32'h00000003);
    st("rearm", 4'b0001);
    $display("Test chain done");
    @(posedge hclk);
    wrap_up();
  end
endmodule

// ---- rtl/fxh_host.sv ----
// Host controller for one cascade-capable 9-bit buffer device.
// Assumes an AHB-Lite master on hclk and the device pins wired straight out.
//
// Our own choices: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps

// Notes on behaviour
// - Width expansion: strobes go in parallel; flags from any one device.
// - Flag outputs are never tied together; one device's flags watched.
// - Depth chains need external combining of room and data flags.
// - First chain device has head select low during reset.
// - Other chain devices have head select high during reset.
// - Each token output is wired to the next device's token input.
// - Token pulses lead strobes by setup, with width and recovery.
// - Paired systems watch room of written and data of read device.
// - Width and depth cascading combine, also in paired use.
module fxh_host (
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic                      hreadyout,
  output logic                      hresp,
  output logic [31:0]               hrdata,
  output logic                      write_strobe_n,
  output logic                      read_strobe_n,
  output logic                      clear_input_n,
  output logic                      chain_head_select,
  output logic                      chain_token_drv,
  output logic                      chain_token_oe,
  output logic [fxh_pkg::DW-1:0]    wdata_pins,
  input  wire logic [fxh_pkg::DW-1:0] rdata_pins,
  input  wire logic                 no_room_ind,
  input  wire logic                 no_data_ind,
  input  wire logic                 half_level_ind
);

  // Three-stage synchronisers on the device flags
  logic [2:0] room_s_q, data_s_q, half_s_q;
  logic       room_ok_q, data_ok_q, half_low_q;

  // Bus side registers
  logic                  ap_valid_q, ap_write_q;
  logic [7:0]            ap_addr_q;
  logic [6:0]            ctrl_q;
  logic [fxh_pkg::DW-1:0] wdata_q, rdata_q;
  logic                  refuse_q, token_seen_q, rdv_q;
  logic                  cmd_go;
  logic [1:0]            cmd_code;

  // Sequencer
  fxh_pkg::fxh_state_t   st_q;
  logic [7:0]            cnt_q;
  fxh_pkg::fxh_cmd_t     op_q;

  // Flag inputs cross into hclk; a change counts when stages two and three
  // agree, so a glitch on a flag pin never reaches the decision logic.
  // Only one device's flags are watched; in a depth chain these pins carry
  // the externally combined flags, never outputs wired together.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      room_s_q <= 3'h0;
      data_s_q <= 3'h0;
      half_s_q <= 3'h7;
    end else begin
      room_s_q <= {room_s_q[1:0], no_room_ind};
      data_s_q <= {data_s_q[1:0], no_data_ind};
      half_s_q <= {half_s_q[1:0], half_level_ind};
    end
  end

  // Filtered flag levels, held while stages disagree
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      room_ok_q  <= 1'b0;
      data_ok_q  <= 1'b0;
      half_low_q <= 1'b0;
    end else begin
      if (room_s_q[1] == room_s_q[2]) room_ok_q <= room_s_q[2];
      if (data_s_q[1] == data_s_q[2]) data_ok_q <= data_s_q[2];
      if (half_s_q[1] == half_s_q[2]) half_low_q <= !half_s_q[2];
    end
  end

  // AHB-Lite address phase capture; slave is always ready, one-cycle answers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_valid_q <= 1'b0;
      ap_write_q <= 1'b0;
      ap_addr_q  <= 8'h00;
    end else if (hready) begin
      ap_valid_q <= hsel && htrans[1];
      ap_write_q <= hwrite;
      ap_addr_q  <= haddr[7:0];
    end
  end

  // Commands launch only when the sequencer is idle; others are dropped
  always_comb begin
    cmd_code = hwdata[fxh_pkg::CTRL_CMD_LSB +: 2];
    cmd_go   = ap_valid_q && ap_write_q &&
               (ap_addr_q == fxh_pkg::REG_CTRL) &&
               (cmd_code != fxh_pkg::FXH_CMD_NONE) &&
               (st_q == fxh_pkg::FXH_IDLE);
  end

  // Control and write data registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q  <= 7'h00;
      wdata_q <= '0;
    end else if (ap_valid_q && ap_write_q) begin
      if (ap_addr_q == fxh_pkg::REG_CTRL) begin
        ctrl_q <= {hwdata[6:4], 4'h0};
      end else if (ap_addr_q == fxh_pkg::REG_WDATA) begin
        wdata_q <= hwdata[fxh_pkg::DW-1:0];
      end
    end
  end

  // Read mux registered on the data phase edge so hrdata is a flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      if (haddr[7:0] == fxh_pkg::REG_CTRL) begin
        hrdata <= {25'h0, ctrl_q};
      end else if (haddr[7:0] == fxh_pkg::REG_WDATA) begin
        hrdata <= {23'h0, wdata_q};
      end else if (haddr[7:0] == fxh_pkg::REG_RDATA) begin
        hrdata <= {23'h0, rdata_q};
      end else if (haddr[7:0] == fxh_pkg::REG_STATUS) begin
        hrdata <= {25'h0, rdv_q, token_seen_q, refuse_q, half_low_q,
                   data_ok_q, room_ok_q, (st_q != fxh_pkg::FXH_IDLE)};
      end else begin
        hrdata <= 32'h0;  // Unmapped reads as zero
      end
    end
  end

  // Bus answers are fixed: zero wait states, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // Strobe sequencer: pulse low, recover high, wait for flags to settle.
  // Device reset holds strobes high through setup and flag settle.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= fxh_pkg::FXH_IDLE;
      cnt_q <= 8'h00;
      op_q <= fxh_pkg::FXH_CMD_NONE;
    end else begin
      case (st_q)
        fxh_pkg::FXH_IDLE: begin
          if (cmd_go) begin
            op_q  <= fxh_pkg::fxh_cmd_t'(cmd_code);
            if (cmd_code == fxh_pkg::FXH_CMD_RESET) begin
              st_q  <= fxh_pkg::FXH_RSLOW;
              cnt_q <= fxh_pkg::PULSE_C;
            end else begin
              st_q  <= fxh_pkg::FXH_LOW;
              cnt_q <= fxh_pkg::PULSE_C;
            end
          end
        end
        fxh_pkg::FXH_LOW: begin
          if (cnt_q == fxh_pkg::ONE_C) begin
            st_q  <= fxh_pkg::FXH_HIGH;
            cnt_q <= fxh_pkg::RECOV_C;
          end else cnt_q <= cnt_q - fxh_pkg::ONE_C;
        end
        fxh_pkg::FXH_HIGH: begin
          if (cnt_q == fxh_pkg::ONE_C) begin
            st_q  <= fxh_pkg::FXH_SETTL;
            cnt_q <= fxh_pkg::FLAG_C;
          end else cnt_q <= cnt_q - fxh_pkg::ONE_C;
        end
        fxh_pkg::FXH_SETTL: begin
          // Waits out flag propagation only, FLAG_C cycles, nothing added for the synchroniser
          if (cnt_q == fxh_pkg::ONE_C) st_q <= fxh_pkg::FXH_IDLE;
          else cnt_q <= cnt_q - fxh_pkg::ONE_C;
        end
        fxh_pkg::FXH_RSLOW: begin
          if (cnt_q == fxh_pkg::ONE_C) begin
            st_q  <= fxh_pkg::FXH_RSREL;
            cnt_q <= fxh_pkg::SETUP_C;
          end else cnt_q <= cnt_q - fxh_pkg::ONE_C;
        end
        fxh_pkg::FXH_RSREL: begin
          if (cnt_q == fxh_pkg::ONE_C) begin
            st_q  <= fxh_pkg::FXH_REPLY;
            cnt_q <= fxh_pkg::FLAG_C;
          end else cnt_q <= cnt_q - fxh_pkg::ONE_C;
        end
        fxh_pkg::FXH_REPLY: begin
          if (cnt_q == fxh_pkg::ONE_C) st_q <= fxh_pkg::FXH_IDLE;
          else cnt_q <= cnt_q - fxh_pkg::ONE_C;
        end
        default: st_q <= fxh_pkg::FXH_IDLE;
      endcase
    end
  end

  // Write strobe; a write is never started while the room flag is low,
  // since the device would ignore it anyway and the word would be lost
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      write_strobe_n <= 1'b1;
      read_strobe_n  <= 1'b1;
      refuse_q       <= 1'b0;
    end else begin
      if (cmd_go && cmd_code == fxh_pkg::FXH_CMD_WRITE) begin
        write_strobe_n <= !room_ok_q;
      end else if (cmd_go && cmd_code == fxh_pkg::FXH_CMD_READ) begin
        read_strobe_n  <= !data_ok_q;
      end else if (st_q == fxh_pkg::FXH_LOW && cnt_q == fxh_pkg::ONE_C) begin
        write_strobe_n <= 1'b1;
        read_strobe_n  <= 1'b1;
      end
      // Refusal is sticky until the next command; a new refusal wins
      if (cmd_go) begin
        refuse_q <= (cmd_code == fxh_pkg::FXH_CMD_WRITE && !room_ok_q) ||
                    (cmd_code == fxh_pkg::FXH_CMD_READ && !data_ok_q);
      end
    end
  end

  // Captures read data at the end of the strobe low phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_q <= '0;
      rdv_q   <= 1'b0;
    end else if (st_q == fxh_pkg::FXH_LOW && cnt_q == fxh_pkg::ONE_C &&
                 op_q == fxh_pkg::FXH_CMD_READ && !read_strobe_n) begin
      rdata_q <= rdata_pins;
      rdv_q   <= 1'b1;
    end else if (cmd_go && cmd_code == fxh_pkg::FXH_CMD_READ) begin
      rdv_q   <= 1'b0;
    end
  end

  // Write data held on the pins from launch to the end of the cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wdata_pins <= '0;
    end else if (cmd_go && cmd_code == fxh_pkg::FXH_CMD_WRITE) begin
      wdata_pins <= wdata_q;
    end
  end

  // Device reset and mode straps: reset clears both device pointers;
  // head select and token input levels held across reset pick the mode.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clear_input_n     <= 1'b1;
      chain_head_select <= 1'b0;
      chain_token_drv   <= 1'b0;
      chain_token_oe    <= 1'b1;
    end else begin
      if (cmd_go && cmd_code == fxh_pkg::FXH_CMD_RESET) begin
        clear_input_n     <= 1'b0;
        chain_head_select <= hwdata[fxh_pkg::CTRL_HEAD];
        chain_token_drv   <= hwdata[fxh_pkg::CTRL_CHAIN];
        chain_token_oe    <= 1'b1;
      end else if (st_q == fxh_pkg::FXH_RSLOW &&
                   cnt_q == fxh_pkg::ONE_C) begin
        clear_input_n <= 1'b1;
      end else if (st_q == fxh_pkg::FXH_REPLY &&
                   cnt_q == fxh_pkg::ONE_C && ctrl_q[fxh_pkg::CTRL_DEPTH]) begin
        // In a chain the token pin belongs to the neighbour, so release it
        chain_token_oe <= 1'b0;
      end
    end
  end

  // In depth-chain mode the half pin carries tokens; latch a low pulse
  // so software sees that this device has passed its token to the next one
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      token_seen_q <= 1'b0;
    end else if (ctrl_q[fxh_pkg::CTRL_DEPTH] && half_low_q) begin
      // A pulse seen in the same cycle as a reset command is kept
      token_seen_q <= 1'b1;
    end else if (cmd_go && cmd_code == fxh_pkg::FXH_CMD_RESET) begin
      token_seen_q <= 1'b0;
    end
  end

endmodule

// ---- shared/fxh_pkg.sv ----
// Package for the cascade buffer host controller: register map, fields,
// command codes and pin timing counts.
// Assumes a 200 MHz hclk and one AHB-Lite slave port of 32-bit words.
package fxh_pkg;
  // Clock period in picoseconds
  localparam int unsigned CLK_PS = 5000;
  // Pin timing figures in nanoseconds
  localparam int unsigned T_PULSE_NS = 120;  // Strobe and reset pulse width
  localparam int unsigned T_RECOV_NS = 20;   // Recovery between strobes
  localparam int unsigned T_SETUP_NS = 100;  // Reset and replay setup
  localparam int unsigned T_FLAG_NS  = 60;   // Flag settle after a strobe
  // Derived cycle counts, least times rounded up
  localparam int unsigned PULSE_CYC = (T_PULSE_NS*1000+CLK_PS-1)/CLK_PS;
  localparam int unsigned RECOV_CYC = (T_RECOV_NS*1000+CLK_PS-1)/CLK_PS;
  localparam int unsigned SETUP_CYC = (T_SETUP_NS*1000+CLK_PS-1)/CLK_PS;
  localparam int unsigned FLAG_CYC  = (T_FLAG_NS*1000+CLK_PS-1)/CLK_PS;
  localparam int unsigned CNT_W     = 8;
  localparam logic [7:0] PULSE_C = 8'(PULSE_CYC);
  localparam logic [7:0] RECOV_C = 8'(RECOV_CYC);
  localparam logic [7:0] SETUP_C = 8'(SETUP_CYC);
  localparam logic [7:0] FLAG_C  = 8'(FLAG_CYC);
  localparam logic [7:0] ONE_C   = 8'h01;

  // Data width of one buffer word
  localparam int unsigned DW = 9;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_WDATA  = 8'h04;
  localparam logic [7:0] REG_RDATA  = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;

  // Control register fields
  localparam int unsigned CTRL_CMD_LSB  = 0;  // 2-bit command, self clearing
  localparam int unsigned CTRL_HEAD     = 4;  // Head level at reset
  localparam int unsigned CTRL_CHAIN    = 5;  // Token pin level at reset
  localparam int unsigned CTRL_DEPTH    = 6;  // Depth-chain mode in use

  // Status register fields
  localparam int unsigned ST_BUSY   = 0;
  localparam int unsigned ST_ROOM   = 1;
  localparam int unsigned ST_DATA   = 2;
  localparam int unsigned ST_HALF   = 3;
  localparam int unsigned ST_REFUSE = 4;
  localparam int unsigned ST_TOKEN  = 5;
  localparam int unsigned ST_RDV    = 6;

  // Commands
  typedef enum logic [1:0] {
    FXH_CMD_NONE   = 2'h0,
    FXH_CMD_WRITE  = 2'h1,
    FXH_CMD_READ   = 2'h2,
    FXH_CMD_RESET  = 2'h3
  } fxh_cmd_t;

  // Pin sequencer states, Gray along strobe path
  typedef enum logic [2:0] {
    FXH_IDLE  = 3'b000,
    FXH_LOW   = 3'b001,
    FXH_HIGH  = 3'b011,
    FXH_SETTL = 3'b010,
    FXH_RSLOW = 3'b110,
    FXH_RSREL = 3'b111,
    FXH_REPLY = 3'b101
  } fxh_state_t;
endpackage
